// [ldc_params.svh]
// Register offsets, field positions and reset values of the LCD control bank
`ifndef LDC_PARAMS_SVH
`define LDC_PARAMS_SVH
// Register byte offsets
`define LDC_OFS_DRIVE_MODE 8'h08
`define LDC_OFS_HYST 8'h0C
`define LDC_OFS_ANALOG 8'h10
`define LDC_OFS_IRQ 8'h18
`define LDC_OFS_SEG_SEL 8'h20
`define LDC_OFS_DISP 8'h28
// Reset values
`define LDC_RST_DRIVE_MODE 7'h00
`define LDC_RST_HYST 2'h1
`define LDC_RST_ANALOG 5'h07
`define LDC_RST_SEG_SEL 28'h0000000
`define LDC_RST_DISP 3'h0
// Interrupt register field positions
`define LDC_IRQ_EN_BIT 0
`define LDC_IRQ_STAT_BIT 1
`define LDC_IRQ_CLR_BIT 2
// Display control: LCD/LED select bit
`define LDC_DISP_LED_BIT 2
// Segment select bit counts: low pin groups, then total
`define LDC_SEG_LOW_N 24
`define LDC_SEG_N 28
`endif

// [ldc_pkg.sv]
// Types shared by the LCD control register bank
package ldc_pkg;
    // Clock source codes
    typedef enum logic [1:0] {
        LDC_CLK_SLOW_RC = 2'h0,
        LDC_CLK_CRYSTAL = 2'h1,
        LDC_CLK_FAST_RC = 2'h2
    } ldc_clk_src_t;
    // Drive scheme of the bias network
    typedef enum logic [1:0] {
        LDC_DRV_SLOW = 2'h0,
        LDC_DRV_FAST = 2'h1,
        LDC_DRV_AUTO = 2'h2
    } ldc_drive_t;
    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ldc_req_t;
    // Analog control outputs
    typedef struct packed {
        logic [1:0] hysteresis_level;
        logic crystal_high_range;
        logic crystal_freq_choice;
        logic crystal_power_down;
        logic capsense_power_down;
        logic converter_power_down;
    } ldc_analog_t;
    // LCD drive controls to waveform generator
    typedef struct packed {
        ldc_clk_src_t lcd_clock_source;
        logic bias_resistance_choice;
        logic [1:0] charge_time_choice;
        ldc_drive_t lcd_drive_scheme;
        logic [9:0] bias_kohm;
        logic [6:0] charge_divisor;
    } ldc_drive_ctrl_t;
endpackage

// [ldc_regs.sv]
// LCD driver control and configuration register bank
//
// Function
// - Two-bit hysteresis code: 300 to 600 mV
// - High range bit: zero 4MHz, one 8MHz
// - Frequency choice: zero 32768Hz, one 4/8MHz
// - Crystal off while power-down set; off after reset (output power-down bit is zero during reset, set from the first clock after)
// - Clock source: 00 slow RC, 01 crystal, else fast RC
// - Bias select: zero 225k, one 900k total
// - Charge time 1/8 to 1/64 COM period
// - Drive code 00: slow charge, selected bias
// - Drive code 01: fast charge, 60k bias
// - Drive codes 10/11: automatic 60k/selected switching
// - Writing one clears scan status; zero ignored
// - Read-only status shows completed scan
// - Read-write interrupt enable bit
// - Segment bits 0-23 map to listed pins
// - Segment bits 24-27 map to PA4-PA7
// - Select bit one: segment mode, zero: IO
// - Display control bit 2 picks LCD or LED
`include "ldc_params.svh"
module ldc_regs (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Register port
    input wire ldc_pkg::ldc_req_t i_req,
    output logic [31:0] o_rdata,
    // Scan end event from the waveform generator
    input wire logic i_scan_done,
    // Analog and LCD controls
    output ldc_pkg::ldc_analog_t o_analog,
    output ldc_pkg::ldc_drive_ctrl_t o_drive,
    // Per-pin segment or IO choice, pin groups in order
    output logic [7:0] o_seg_pa_hi,
    output logic [7:0] o_seg_pb_hi,
    output logic [1:0] o_seg_pc_lo,
    output logic [5:0] o_seg_pc_hi,
    output logic [3:0] o_seg_pa_lo,
    // Segment buffers drive LED matrix when high
    output logic o_drive_led,
    // Level interrupt
    output logic o_irq
);
    import ldc_pkg::*;

    // Stored fields
    logic [6:0] drive_mode;
    logic [1:0] hyst;
    logic [4:0] analog;
    logic [27:0] seg_sel;
    logic [2:0] disp;
    logic irq_en;
    logic scan_stat;
    // Decoded write strobes
    logic wr_drive;
    logic wr_hyst;
    logic wr_analog;
    logic wr_irq;
    logic wr_seg;
    logic wr_disp;
    // Next drive controls
    ldc_drive_ctrl_t next_drive;
    logic [31:0] next_rdata;

    // Address decode for writes
    always_comb begin
        wr_drive = i_req.wr && (i_req.addr == `LDC_OFS_DRIVE_MODE);
        wr_hyst = i_req.wr && (i_req.addr == `LDC_OFS_HYST);
        wr_analog = i_req.wr && (i_req.addr == `LDC_OFS_ANALOG);
        wr_irq = i_req.wr && (i_req.addr == `LDC_OFS_IRQ);
        wr_seg = i_req.wr && (i_req.addr == `LDC_OFS_SEG_SEL);
        wr_disp = i_req.wr && (i_req.addr == `LDC_OFS_DISP);
    end

    // LCD drive mode register
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            drive_mode <= `LDC_RST_DRIVE_MODE;
        end else if (wr_drive) begin
            drive_mode <= i_req.wdata[6:0];
        end
    end

    // Hysteresis select register
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hyst <= `LDC_RST_HYST;
        end else if (wr_hyst) begin
            hyst <= i_req.wdata[1:0];
        end
    end

    // Analog power switch register, crystal off after reset
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            analog <= `LDC_RST_ANALOG;
        end else if (wr_analog) begin
            analog <= i_req.wdata[4:0];
        end
    end

    // Segment pin select register
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            seg_sel <= `LDC_RST_SEG_SEL;
        end else if (wr_seg) begin
            seg_sel <= i_req.wdata[27:0];
        end
    end

    // Display control register
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            disp <= `LDC_RST_DISP;
        end else if (wr_disp) begin
            disp <= i_req.wdata[2:0];
        end
    end

    // Interrupt enable bit
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_en <= 1'h0;
        end else if (wr_irq) begin
            irq_en <= i_req.wdata[`LDC_IRQ_EN_BIT];
        end
    end

    // Sticky scan status; a new scan end wins over a clear
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scan_stat <= 1'h0;
        end else if (i_scan_done) begin
            scan_stat <= 1'h1;
        end else if (wr_irq && i_req.wdata[`LDC_IRQ_CLR_BIT]) begin
            scan_stat <= 1'h0;
        end
    end

    // Decode drive controls
    always_comb begin
        next_drive.bias_resistance_choice = drive_mode[4];
        next_drive.charge_time_choice = drive_mode[3:2];
        // Source code 10 and 11 both pick the fast RC
        case (drive_mode[6:5])
            2'h0: next_drive.lcd_clock_source = LDC_CLK_SLOW_RC;
            2'h1: next_drive.lcd_clock_source = LDC_CLK_CRYSTAL;
            default: next_drive.lcd_clock_source = LDC_CLK_FAST_RC;
        endcase
        // Charge time as divisor of COM period
        case (drive_mode[3:2])
            2'h0: next_drive.charge_divisor = 7'h08;
            2'h1: next_drive.charge_divisor = 7'h10;
            2'h2: next_drive.charge_divisor = 7'h20;
            default: next_drive.charge_divisor = 7'h40;
        endcase
        // Bias total in kilo-ohm
        case (drive_mode[1:0])
            2'h0: begin
                next_drive.lcd_drive_scheme = LDC_DRV_SLOW;
                next_drive.bias_kohm = drive_mode[4] ? 10'h384 : 10'h0E1;
            end
            2'h1: begin
                next_drive.lcd_drive_scheme = LDC_DRV_FAST;
                next_drive.bias_kohm = 10'h03C;
            end
            default: begin
                // Slow total reported; generator switches to 60k itself
                next_drive.lcd_drive_scheme = LDC_DRV_AUTO;
                next_drive.bias_kohm = drive_mode[4] ? 10'h384 : 10'h0E1;
            end
        endcase
    end

    // Registered control outputs
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_drive <= '0;
            o_analog <= '0;
        end else begin
            o_drive <= next_drive;
            o_analog <= {hyst, analog};
        end
    end

    // Pin mode outputs
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_seg_pa_hi <= 8'h00;
            o_seg_pb_hi <= 8'h00;
            o_seg_pc_lo <= 2'h0;
            o_seg_pc_hi <= 6'h00;
            o_seg_pa_lo <= 4'h0;
        end else begin
            o_seg_pa_hi <= seg_sel[7:0];
            o_seg_pb_hi <= seg_sel[15:8];
            o_seg_pc_lo <= seg_sel[17:16];
            o_seg_pc_hi <= seg_sel[23:18];
            o_seg_pa_lo <= seg_sel[27:24];
        end
    end

    // LCD or LED select and interrupt line
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_drive_led <= 1'h0;
            o_irq <= 1'h0;
        end else begin
            o_drive_led <= disp[`LDC_DISP_LED_BIT];
            o_irq <= scan_stat && irq_en;
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 32'h00000000;
        case (i_req.addr)
            `LDC_OFS_DRIVE_MODE: next_rdata = {25'h0, drive_mode};
            `LDC_OFS_HYST: next_rdata = {30'h0, hyst};
            `LDC_OFS_ANALOG: next_rdata = {27'h0, analog};
            `LDC_OFS_IRQ: next_rdata = {30'h0, scan_stat, irq_en};
            `LDC_OFS_SEG_SEL: next_rdata = {4'h0, seg_sel};
            `LDC_OFS_DISP: next_rdata = {29'h0, disp};
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 32'h00000000;
        end else if (i_req.rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

    // Interrupt follows status and enable
    property p_irq_follows;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        1'b1 |=> (o_irq == ($past(scan_stat) && $past(irq_en)));
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("irq does not follow status and enable");

    // Scan end sets status even when clear arrives together
    property p_set_wins;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        i_scan_done |=> scan_stat ##1 (o_irq == $past(irq_en));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("scan end lost");

    // Clear by one drops status
    property p_clear;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (wr_irq && i_req.wdata[2] && !i_scan_done) |=> !scan_stat;
    endproperty
    a_clear: assert property (p_clear)
        else $error("status not cleared");

    // Zero in clear bit keeps status
    property p_clear_zero;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (scan_stat && !(wr_irq && i_req.wdata[2])) |=> scan_stat;
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("status dropped without clear");

    // Status read back one cycle later
    property p_stat_read;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_req.rd && i_req.addr == 8'h18) |=>
            (o_rdata[1] == $past(scan_stat)) && (o_rdata[31:2] == 30'h0);
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("status read wrong");

    // Fast charge code gives 60k two cycles after write
    property p_fast;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (wr_drive && i_req.wdata[1:0] == 2'h1) |=> ##1
            (o_drive.bias_kohm == 10'h03C);
    endproperty
    a_fast: assert property (p_fast)
        else $error("fast charge bias wrong");

    // Slow mode bias follows bias select
    property p_slow;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_rst_b && drive_mode[1:0] == 2'h0) |=> (o_drive.bias_kohm ==
            ($past(drive_mode[4]) ? 10'h384 : 10'h0E1));
    endproperty
    a_slow: assert property (p_slow)
        else $error("slow charge bias wrong");

    // Source code 11 picks the fast RC as clock source
    property p_clk_src;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (drive_mode[6:5] == 2'h3) |=> (o_drive.lcd_clock_source ==
            LDC_CLK_FAST_RC);
    endproperty
    a_clk_src: assert property (p_clk_src)
        else $error("clock source decode wrong");

    // Top segment bits reach PA4-PA7
    property p_seg_hi;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        1'b1 |=> (o_seg_pa_lo == $past(seg_sel[27:24]));
    endproperty
    a_seg_hi: assert property (p_seg_hi)
        else $error("PA4-PA7 select wrong");

    // Analog fields reach their outputs one cycle later
    property p_analog;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        i_rst_b |=> (o_analog == $past({hyst, analog}));
    endproperty
    a_analog: assert property (p_analog)
        else $error("analog outputs wrong");

    // Automatic scheme keeps the selected slow total
    property p_auto;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_rst_b && drive_mode[1]) |=>
            (o_drive.lcd_drive_scheme == LDC_DRV_AUTO) &&
            (o_drive.bias_kohm ==
            ($past(drive_mode[4]) ? 10'h384 : 10'h0E1));
    endproperty
    a_auto: assert property (p_auto)
        else $error("automatic drive scheme wrong");

    // Charge divisor doubles with each charge time code
    property p_charge;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        i_rst_b |=> (o_drive.charge_divisor ==
            (7'h08 << $past(drive_mode[3:2])));
    endproperty
    a_charge: assert property (p_charge)
        else $error("charge divisor wrong");

    // Bias select bit passes to the generator
    property p_bias_sel;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        1'b1 |=> (o_drive.bias_resistance_choice == $past(drive_mode[4]));
    endproperty
    a_bias_sel: assert property (p_bias_sel)
        else $error("bias select wrong");

    // Code 01 picks the crystal as clock source
    property p_src_crystal;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (drive_mode[6:5] == 2'h1) |=>
            (o_drive.lcd_clock_source == LDC_CLK_CRYSTAL);
    endproperty
    a_src_crystal: assert property (p_src_crystal)
        else $error("crystal source decode wrong");

    // Low segment bits reach the PA, PB and PC groups in order
    property p_seg_lo;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        1'b1 |=> ({o_seg_pc_hi, o_seg_pc_lo, o_seg_pb_hi, o_seg_pa_hi} ==
            $past(seg_sel[23:0]));
    endproperty
    a_seg_lo: assert property (p_seg_lo)
        else $error("segment pin select wrong");

    // Display control bit two picks the LED matrix
    property p_led_sel;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        1'b1 |=> (o_drive_led == $past(disp[`LDC_DISP_LED_BIT]));
    endproperty
    a_led_sel: assert property (p_led_sel)
        else $error("display select wrong");

    // Enable bit read back beside the status
    property p_en_read;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_req.rd && i_req.addr == `LDC_OFS_IRQ) |=>
            (o_rdata[0] == $past(irq_en));
    endproperty
    a_en_read: assert property (p_en_read)
        else $error("enable read wrong");

    // Scenarios
    c_irq: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
        irq_en && i_scan_done ##2 o_irq);
    c_clear: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
        scan_stat ##1 (wr_irq && i_req.wdata[2]) ##1 !scan_stat);
    c_auto: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_drive.lcd_drive_scheme == LDC_DRV_AUTO);
endmodule

// [ldc_scan_model.sv]
// Waveform generator stand-in that reports the end of each LCD scan
module ldc_scan_model #(
    parameter int SCAN_CYCLES = 5
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Start of a full scan of all COM phases
    input wire logic i_start,
    // One-cycle end of scan pulse
    output logic o_scan_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt; // Cycles left in the scan

    // Count the scan down, pulse once as it ends
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= 0;
            o_scan_done <= 1'b0;
        end else begin
            o_scan_done <= (cnt == 1);
            if (i_start) begin
                cnt <= SCAN_CYCLES;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// [tb.sv]
// Self-checking bench of the LCD control register bank
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ldc_pkg::*;
    logic clk = 1'b0; // Core clock
    logic rst_b = 1'b0; // Active low reset
    logic go = 1'b0; // Scan start to the model
    logic scan; // Scan end pulse
    ldc_req_t req = '0; // Register request
    logic [31:0] rdata;
    ldc_analog_t ana;
    ldc_drive_ctrl_t drv;
    logic [7:0] pah, pbh;
    logic [1:0] pcl;
    logic [5:0] pch;
    logic [3:0] pal;
    logic led, irq;
    logic rd_seen = 1'b0; // Read taken on the last edge
    logic [31:0] q[$]; // Expected read data
    logic [31:0] d, e, m;
    logic [1:0] cs, sc;
    logic [9:0] bk;
    int mismatches = 0, num_checks = 0, seed = 27;

    // 250 MHz clock
    always #2 clk = ~clk;

    ldc_regs DUT (.i_core_clk(clk), .i_rst_b(rst_b), .i_req(req),
        .o_rdata(rdata), .i_scan_done(scan), .o_analog(ana),
        .o_drive(drv), .o_seg_pa_hi(pah), .o_seg_pb_hi(pbh),
        .o_seg_pc_lo(pcl), .o_seg_pc_hi(pch), .o_seg_pa_lo(pal),
        .o_drive_led(led), .o_irq(irq));

    ldc_scan_model u_scan (.i_core_clk(clk), .i_rst_b(rst_b),
        .i_start(go), .o_scan_done(scan));

    // Compare one value, count and report
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask

    // One-cycle write
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge clk);
        req <= '{a, v, 1'b1, 1'b0};
    endtask

    // One-cycle read, expected data noted
    task automatic rd(logic [7:0] a, logic [31:0] x);
        @(posedge clk);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        q.push_back(x);
    endtask

    // Go idle and let the written value reach the outputs
    task automatic settle;
        @(posedge clk);
        req <= '0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Run one scan in the model
    task automatic kick;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
    endtask

    // Verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Read data monitor, one cycle after each read
    always @(posedge clk) begin
        if (rd_seen) begin
            m = q.pop_front();
            chk("rdata", m, rdata);
        end
        rd_seen <= req.rd;
    end

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        test_done;
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        // Reset values
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'h1);
        rd(8'h10, 32'h7);
        rd(8'h18, 32'h0);
        rd(8'h20, 32'h0);
        rd(8'h28, 32'h0);
        settle;
        chk("analog", 32'h27, 32'(ana));
        chk("drive", 32'({10'h0, 10'h0E1, 7'h08}), 32'(drv));
        // Every clock source and drive scheme code
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            d[1:0] = i[1:0];
            d[6:5] = i[3:2];
            wr(8'h08, d);
            settle;
            cs = (d[6:5] == 2'h0) ? 2'h0 : (d[6:5] == 2'h1) ? 2'h1 : 2'h2;
            sc = (d[1:0] == 2'h0) ? 2'h0 : (d[1:0] == 2'h1) ? 2'h1 : 2'h2;
            bk = (sc == 2'h1) ? 10'h03C : d[4] ? 10'h384 : 10'h0E1;
            e = 32'({cs, d[4], d[3:2], sc, bk, 7'h08 << d[3:2]});
            chk("drive", e, 32'(drv));
            rd(8'h08, d & 32'h7F);
        end
        // Hysteresis codes and analog switches
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            e = $random(seed);
            d[1:0] = i[1:0];
            wr(8'h0C, d);
            wr(8'h10, e);
            settle;
            chk("analog", 32'({d[1:0], e[4:0]}), 32'(ana));
            rd(8'h0C, d & 32'h3);
            rd(8'h10, e & 32'h1F);
        end
        // Segment pin groups and display select
        for (int i = 0; i < 3; i++) begin
            d = $random(seed);
            e = $random(seed);
            e[2] = i[0];
            wr(8'h20, d);
            wr(8'h28, e);
            settle;
            m = 32'({pal, pch, pcl, pbh, pah});
            chk("seg", d & 32'h0FFFFFFF, m);
            chk("led", 32'(e[2]), 32'(led));
            rd(8'h20, d & 32'h0FFFFFFF);
            rd(8'h28, e & 32'h7);
        end
        // Scan end with interrupt masked
        wr(8'h18, 32'h0);
        settle;
        kick;
        chk("irq", 32'h0, 32'(irq));
        rd(8'h18, 32'h2);
        wr(8'h18, 32'h1);
        settle;
        chk("irq", 32'h1, 32'(irq));
        // Zero in the clear bit keeps the status
        wr(8'h18, 32'hFFFFFFF3);
        settle;
        chk("irq", 32'h1, 32'(irq));
        rd(8'h18, 32'h3);
        wr(8'h18, 32'h5);
        settle;
        chk("irq", 32'h0, 32'(irq));
        rd(8'h18, 32'h1);
        // Status cannot be set by software
        wr(8'h18, 32'h3);
        settle;
        chk("irq", 32'h0, 32'(irq));
        rd(8'h18, 32'h1);
        // Scan end with interrupt enabled
        settle;
        kick;
        chk("irq", 32'h1, 32'(irq));
        rd(8'h18, 32'h3);
        // Unmapped places
        wr(8'h04, 32'hFFFFFFFF);
        rd(8'h04, 32'h0);
        rd(8'h2C, 32'h0);
        settle;
        test_done;
    end
endmodule
